// ===== hw/p6gpio_pkg.sv
// Operation
// - Output data register at 0xFFD9, eight bits read/write, resets to zero.
// - Read with direction bit 1 returns the latched output data bit.
// - Read with direction bit 0 returns the sampled external pin level.
// - Direction bit 1 drives the pin; direction bit 0 leaves it input.
// - Direction register at 0xFFE9 is write-only, resets zero, reads all ones.
// - Direction and data apply only while the pin is general-purpose I/O.
// - Pull-up control register at 0xFFE3, eight bits read/write, resets zero.
// - Pull-up on only when direction is 0 and pull-up bit is 1.
// - After reset every pull-up stays off until software enables it.
// - Upper pins carry segment outputs when select field is 0100 to 1011.
// - Lower pins carry segment outputs when select field is 0011 to 1010.
// - Standby leaves pins floating, pulled-up pins present high; sleep holds the last pin state.
`default_nettype none
package p6gpio_pkg;
  localparam logic [15:0] OFFSET_OUTPUT_DATA = 16'hFFD9;
  localparam logic [15:0] OFFSET_PULLUP      = 16'hFFE3;
  localparam logic [15:0] OFFSET_DIRECTION   = 16'hFFE9;
  localparam logic [7:0]  RESET_OUTPUT_DATA  = 8'h00;
  localparam logic [7:0]  RESET_PULLUP       = 8'h00;
  localparam logic [7:0]  RESET_DIRECTION    = 8'h00;
  localparam logic [7:0]  DIRECTION_READBACK = 8'hFF;
  localparam logic [3:0]  UPPER_SEG_LOW      = 4'h4;
  localparam logic [3:0]  UPPER_SEG_HIGH     = 4'hB;
  localparam logic [3:0]  LOWER_SEG_LOW      = 4'h3;
  localparam logic [3:0]  LOWER_SEG_HIGH     = 4'hA;
  localparam logic [1:0]  AXI_OKAY           = 2'h0;
  localparam logic [1:0]  AXI_SLVERR         = 2'h2;
  typedef enum logic [2:0]
  {
    P6G_MODE_ACTIVE  = 3'h1,
    P6G_MODE_SLEEP   = 3'h2,
    P6G_MODE_STANDBY = 3'h4
  } p6g_mode_type;
  localparam logic [1:0] MODE_CODE_SLEEP   = 2'h1;
  localparam logic [1:0] MODE_CODE_STANDBY = 2'h2;
endpackage
`default_nettype wire

// ===== hw/p6gpio_top.sv
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module p6gpio_top
#(
  parameter int ADDR_WIDTH = 16
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [3:0]            segment_select_field,
  input  wire logic [7:0]            lcd_segment_output,
  input  wire logic [1:0]            power_mode,
  input  wire logic [7:0]            pin_in,
  output var  logic [7:0]            pin_out,
  output var  logic [7:0]            pin_oe,
  output var  logic [7:0]            pin_pullup_en
);
  // Full 16-bit offsets are compared, so narrower buses cannot reach them
  if (ADDR_WIDTH < 16 || ADDR_WIDTH > 32)
  begin : g_addr_width_check
    $error("ADDR_WIDTH must lie between 16 and 32");
  end

  function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] low_addr(input logic [ADDR_WIDTH-1:0] a);
    low_addr = a[15:0];
  endfunction

  logic [7:0] port_output_data;
  logic [7:0] port_direction_control;
  logic [7:0] port_pullup_control;
  p6gpio_pkg::p6g_mode_type mode;
  p6gpio_pkg::p6g_mode_type next_mode;

  // Write channel capture, address and data in either order
  logic                  aw_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  w_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held || aw_take;
  wire w_have  = w_held || w_take;
  wire [ADDR_WIDTH-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire wr_hi_zero = (ADDR_WIDTH == 16) || (wr_addr >> 16) == '0;
  wire wr_is_data = wr_hi_zero && low_addr(wr_addr) == p6gpio_pkg::OFFSET_OUTPUT_DATA;
  wire wr_is_pull = wr_hi_zero && low_addr(wr_addr) == p6gpio_pkg::OFFSET_PULLUP;
  wire wr_is_dir  = wr_hi_zero && low_addr(wr_addr) == p6gpio_pkg::OFFSET_DIRECTION;
  wire wr_mapped  = wr_is_data || wr_is_pull || wr_is_dir;
  wire wr_lane0   = wr_fire && wr_strb[0];

  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_hi_zero = (ADDR_WIDTH == 16) || (s_axi_araddr >> 16) == '0;
  wire rd_is_data = rd_hi_zero && low_addr(s_axi_araddr) == p6gpio_pkg::OFFSET_OUTPUT_DATA;
  wire rd_is_pull = rd_hi_zero && low_addr(s_axi_araddr) == p6gpio_pkg::OFFSET_PULLUP;
  wire rd_is_dir  = rd_hi_zero && low_addr(s_axi_araddr) == p6gpio_pkg::OFFSET_DIRECTION;
  wire rd_mapped  = rd_is_data || rd_is_pull || rd_is_dir;

  // Per-pin mixing of latch and live level
  wire [7:0] port_read_value = (port_direction_control & port_output_data)
                             | (~port_direction_control & pin_in);
  wire [7:0] rd_byte = rd_is_data ? port_read_value
                     : rd_is_pull ? port_pullup_control
                     : rd_is_dir  ? p6gpio_pkg::DIRECTION_READBACK
                     : 8'h00;

  // Segment ownership per half-port
  wire upper_seg = in_range(segment_select_field, p6gpio_pkg::UPPER_SEG_LOW,
                            p6gpio_pkg::UPPER_SEG_HIGH);
  wire lower_seg = in_range(segment_select_field, p6gpio_pkg::LOWER_SEG_LOW,
                            p6gpio_pkg::LOWER_SEG_HIGH);
  wire [7:0] seg_owned = {{4{upper_seg}}, {4{lower_seg}}};

  wire [7:0] gpio_drive = ~seg_owned & port_direction_control;
  wire [7:0] func_oe    = seg_owned | gpio_drive;
  wire [7:0] func_out   = (seg_owned & lcd_segment_output) | (gpio_drive & port_output_data);
  wire [7:0] func_pull  = ~seg_owned & ~port_direction_control & port_pullup_control;

  always_comb
  begin
    case (power_mode)
      p6gpio_pkg::MODE_CODE_SLEEP:   next_mode = p6gpio_pkg::P6G_MODE_SLEEP;
      p6gpio_pkg::MODE_CODE_STANDBY: next_mode = p6gpio_pkg::P6G_MODE_STANDBY;
      default:                       next_mode = p6gpio_pkg::P6G_MODE_ACTIVE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode <= p6gpio_pkg::P6G_MODE_ACTIVE;
    else
      mode <= next_mode;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_output_data       <= p6gpio_pkg::RESET_OUTPUT_DATA;
      port_pullup_control    <= p6gpio_pkg::RESET_PULLUP;
      port_direction_control <= p6gpio_pkg::RESET_DIRECTION;
    end
    else if (wr_lane0)
    begin
      if (wr_is_data)
        port_output_data <= wr_data[7:0];
      if (wr_is_pull)
        port_pullup_control <= wr_data[7:0];
      if (wr_is_dir)
        port_direction_control <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      w_held        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= p6gpio_pkg::AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_fire;
      s_axi_wready  <= !w_have && !s_axi_bvalid && !wr_fire;
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? p6gpio_pkg::AXI_OKAY : p6gpio_pkg::AXI_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end
      else
      begin
        if (aw_take)
          aw_held <= 1'b1;
        if (w_take)
          w_held <= 1'b1;
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= p6gpio_pkg::AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_mapped ? p6gpio_pkg::AXI_OKAY : p6gpio_pkg::AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pin drivers; sleep holds the last state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out       <= 8'h00;
      pin_oe        <= 8'h00;
      pin_pullup_en <= 8'h00;
    end
    else
    begin
      case (next_mode)
        p6gpio_pkg::P6G_MODE_ACTIVE:
        begin
          pin_out       <= func_out;
          pin_oe        <= func_oe;
          pin_pullup_en <= func_pull;
        end
        p6gpio_pkg::P6G_MODE_STANDBY:
        begin
          pin_out       <= 8'h00;
          pin_oe        <= 8'h00;
          pin_pullup_en <= func_pull;
        end
        p6gpio_pkg::P6G_MODE_SLEEP:
        begin
          pin_out       <= pin_out;
          pin_oe        <= pin_oe;
          pin_pullup_en <= pin_pullup_en;
        end
        default:
        begin
          pin_out       <= 8'h00;
          pin_oe        <= 8'h00;
          pin_pullup_en <= 8'h00;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/p6g_checker.sv
`default_nettype none
module p6g_checker
#(
  parameter int ADDR_WIDTH = 16
)
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic [3:0]            segment_select_field,
  input wire logic [7:0]            lcd_segment_output,
  input wire logic [1:0]            power_mode,
  input wire logic [7:0]            pin_out,
  input wire logic [7:0]            pin_oe,
  input wire logic [7:0]            pin_pullup_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic up_seg = segment_select_field inside {[4'h4:4'hB]};
  wire logic lo_seg = segment_select_field inside {[4'h3:4'hA]};
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> pin_oe == 8'h00 && pin_pullup_en == 8'h00)
    else $error("pins not quiet after reset");
  a_upper_seg: assert property (power_mode == 2'h0 && up_seg |=>
    pin_oe[7:4] == 4'hF && pin_out[7:4] == $past(lcd_segment_output[7:4])) else $error("upper segment wrong");
  a_lower_seg: assert property (power_mode == 2'h0 && lo_seg |=>
    pin_oe[3:0] == 4'hF && pin_out[3:0] == $past(lcd_segment_output[3:0])) else $error("lower segment wrong");
  a_pullup_exclusive: assert property ((pin_pullup_en & pin_oe) == 8'h00)
    else $error("pull-up on driven pin");
  a_standby_float: assert property (power_mode == 2'h2 |=> pin_oe == 8'h00)
    else $error("pin driven in standby");
  a_sleep_hold: assert property (power_mode == 2'h1 |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved in sleep");
  a_write_answer: assert property (s_wr_both |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("bad read response");
  a_dir_ones: assert property (s_rd_taken ##0 s_axi_araddr == ADDR_WIDTH'(16'hFFE9) |=>
    s_axi_rdata == 32'h0000_00FF) else $error("direction read not all ones");
endmodule
bind p6gpio_top p6g_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.*);
`default_nettype wire

// ===== test/p6g_pins.sv
`default_nettype none
module p6g_pins
(
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_en,
  output var  logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt = 8'h55;
  // Undriven pins never settle
  always @(posedge aclk) flt <= ~flt;
  always_comb
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_drv[i] : pin_pullup_en[i] ? 1'b1 : flt[i];
endmodule
`default_nettype wire

// ===== test/port6_gpio_segment_shared_pins_tb.sv
`default_nettype none
module port6_gpio_segment_shared_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0;
  logic [15:0] s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  segment_select_field = 4'h0;
  logic [7:0]  lcd_segment_output = 8'h5A;
  logic [1:0]  power_mode = 2'h0;
  logic [7:0]  ext_en = 8'hFF;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup_en;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  p6gpio_top #(.ADDR_WIDTH(16)) DUT (.*);
  p6g_pins u_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_drv(8'h3C), .ext_en(ext_en), .pin_in(pin_in));
  initial forever #2 aclk = ~aclk;
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic t_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("oe", 32'h0, pin_oe);
    chk("pullup", 32'h0, pin_pullup_en);
    rd(16'hFFD9, 32'h3C, 2'h0);
    rd(16'hFFE3, 32'h0, 2'h0);
    rd(16'hFFE9, 32'hFF, 2'h0);
  endtask
  task automatic t_gpio();
    wr(16'hFFE9, 8'hF0, 2'h0);
    rd(16'hFFD9, 32'h0C, 2'h0);
    wr(16'hFFD9, 8'hA5, 2'h0);
    wr(16'hFFE3, 8'hFF, 2'h0);
    settle();
    chk("oe", 32'hF0, pin_oe);
    chk("out", 32'hA0, pin_out & pin_oe);
    chk("pullup", 32'h0F, pin_pullup_en);
    rd(16'hFFD9, 32'hAC, 2'h0);
    rd(16'hFFE3, 32'hFF, 2'h0);
    @(posedge aclk);
    ext_en <= 8'hF0;
    settle();
    rd(16'hFFD9, 32'hAF, 2'h0);
    @(posedge aclk);
    ext_en <= 8'hFF;
    wr(16'hFFDA, 8'h11, 2'h2);
    rd(16'hFFDA, 32'h0, 2'h2);
  endtask
  task automatic t_seg();
    logic up, lo;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge aclk);
      segment_select_field <= 4'(i);
      settle();
      up = i >= 4 && i <= 11;
      lo = i >= 3 && i <= 10;
      chk("oe", {24'h0, 4'hF, lo ? 4'hF : 4'h0}, pin_oe);
      chk("out", {24'h0, up ? 4'h5 : 4'hA, lo ? 4'hA : 4'h0}, pin_out & pin_oe);
      chk("pullup", {28'h0, lo ? 4'h0 : 4'hF}, pin_pullup_en);
    end
    @(posedge aclk);
    segment_select_field <= 4'h0;
  endtask
  task automatic t_modes();
    @(posedge aclk);
    power_mode <= 2'h2;
    settle();
    chk("oe", 32'h0, pin_oe);
    chk("pullup", 32'h0F, pin_pullup_en);
    @(posedge aclk);
    power_mode <= 2'h1;
    wr(16'hFFD9, 8'h5A, 2'h0);
    settle();
    chk("oe", 32'h0, pin_oe);
    @(posedge aclk);
    power_mode <= 2'h0;
    settle();
    chk("out", 32'h50, pin_out & pin_oe);
  endtask
  initial
  begin
    t_reset();
    t_gpio();
    t_seg();
    t_modes();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
